//--- pdw_consts.svh
/*
 * Timing counts, field positions and data reset value for the parallel DAC
 * write port controller. Assumes a 100 ns system clock.
 */
`ifndef PDW_CONSTS_SVH
`define PDW_CONSTS_SVH

`define PDW_CLK_PERIOD_NS 100
`define PDW_T_CS_WE_NS 15
`define PDW_T_SU_REG_NS 20
`define PDW_T_HOLD_NS 5
`define PDW_T_WE_LD_NS 5
`define PDW_T_WE_HIGH_NS 20
`define PDW_T_LD_LOW_NS 23
`define PDW_CYC(ns) (((ns) + `PDW_CLK_PERIOD_NS - 1) / `PDW_CLK_PERIOD_NS)
`define PDW_SPD_BIT 0
`define PDW_PWR_BIT 1
`define PDW_REF_LO_BIT 3
`define PDW_REF_HI_BIT 4
`define PDW_DATA_RESET 12'h000

`endif

//--- pdw_dev_model.sv
/* Behavioural model of the parallel-input DAC on the far side.
   Assumes pins are driven by pdw_host; no clock of its own. */
`timescale 1ns/1ns
module pdw_dev_model (
    // Device pins
    input wire logic i_select_n,
    input wire logic i_write_n,
    input wire logic i_reg_select,
    input wire logic [11:0] i_data,
    input wire logic i_load_n,
    // Observed state
    output logic [11:0] o_hold,
    output logic [11:0] o_setup,
    output logic [11:0] o_dac,
    output logic o_viol
);
    time t_rise;
    initial begin
        o_hold = 12'h000;
        o_setup = 12'h000;
        o_dac = 12'h000;
        o_viol = 1'b0;
        t_rise = 0;
    end
    always @(posedge i_write_n) begin
        t_rise = $time;
        if (!i_select_n) begin
            if (i_reg_select) begin
                o_setup = 12'h000;
                o_setup[1:0] = i_data[1:0];
                o_setup[4:3] = i_data[4:3];
            end else begin
                o_hold = i_data;
            end
        end
    end
    // Level-sensitive, so a tied-low load follows every latch write
    always @(o_hold or i_load_n) if (!i_load_n) o_dac = o_hold;
    always @(negedge i_load_n) if ($time - t_rise < 5) o_viol = 1'b1;
endmodule : pdw_dev_model

//--- pdw_host.sv
/*
 * Host-side controller that writes a 12-bit parallel-input DAC through
 * its select, write strobe, register-select and load pins.
 * Assumes a 10 MHz clock, synchronous inputs and a clockless device.
 */
// Notes on behaviour
// - Data captured on strobe rising edge only while select is low.
// - Register-select 0 writes holding latch, 1 writes setup word.
// - Host waits one clock cycle (100 ns) after strobe rise before driving load low.
// - With an external reference applied, host selects external encoding.
`timescale 1ns/1ns
`include "pdw_consts.svh"
module pdw_host #(
    parameter int DATA_W = 12
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // User command port
    input wire logic i_req,
    input wire logic i_req_setup,
    input wire logic [DATA_W-1:0] i_code,
    input wire logic i_speed_choice,
    input wire logic i_powerdown_ctl,
    input wire logic [1:0] i_ref_choice,
    input wire logic i_ext_ref_present,
    input wire logic i_load_tied,
    output logic o_busy,
    output logic o_done,
    // Device pins
    output logic [DATA_W-1:0] o_parallel_data_bus,
    output logic o_select_n,
    output logic o_write_n,
    output logic o_reg_select,
    output logic o_output_load_n
);
    localparam int SEL_CYC = `PDW_CYC(`PDW_T_CS_WE_NS);
    localparam int SU_CYC = `PDW_CYC(`PDW_T_SU_REG_NS);
    localparam int HOLD_CYC = `PDW_CYC(`PDW_T_HOLD_NS);
    localparam int WE_LD_CYC = `PDW_CYC(`PDW_T_WE_LD_NS);
    localparam int LD_CYC = `PDW_CYC(`PDW_T_LD_LOW_NS);

    // Elaboration checks: the wait counter is four bits wide
    if (DATA_W != 12) begin : g_width_check
        $error("pdw_host supports only a 12-bit code");
    end
    if (SEL_CYC > 15 || SU_CYC > 15 ||
        HOLD_CYC > 15 || LD_CYC > 15) begin : g_count_check
        $error("pdw_host timing count does not fit the counter");
    end
    // The hold wait also spaces the strobe rise from the load fall
    if (WE_LD_CYC > HOLD_CYC) begin : g_load_check
        $error("pdw_host load spacing exceeds the hold wait");
    end

    default clocking cb_sys @(posedge i_clk_sys);
    endclocking
    default disable iff (i_reset);

    pdw_pkg::pdw_state_e state_reg, state_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [DATA_W-1:0] bus_reg, bus_next;
    logic sel_n_reg, sel_n_next;
    logic we_n_reg, we_n_next;
    logic rs_reg, rs_next;
    logic ld_n_reg, ld_n_next;
    logic done_reg, done_next;
    logic busy_reg, busy_next;

    // Guard external reference: force an external encoding
    function automatic logic [1:0] pdw_ref_fix(input logic [1:0] r,
                                               input logic ext);
        pdw_ref_fix = r;
        if (ext && (r == pdw_pkg::PDW_REF_1V024 ||
                    r == pdw_pkg::PDW_REF_2V048)) begin
            pdw_ref_fix = pdw_pkg::PDW_REF_EXT0;
        end
    endfunction : pdw_ref_fix

    function automatic logic [DATA_W-1:0] pdw_setup_word(
            input logic speed_choice, input logic powerdown_ctl, input logic [1:0] r);
        logic [DATA_W-1:0] w;
        w = '0;
        w[`PDW_SPD_BIT] = speed_choice;
        w[`PDW_PWR_BIT] = powerdown_ctl;
        w[`PDW_REF_HI_BIT:`PDW_REF_LO_BIT] = r;
        pdw_setup_word = w;
    endfunction : pdw_setup_word

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        bus_next = bus_reg;
        sel_n_next = sel_n_reg;
        we_n_next = we_n_reg;
        rs_next = rs_reg;
        // Load rests high unless tied, so untying releases it
        ld_n_next = i_load_tied ? 1'b0 : 1'b1;
        done_next = 1'b0;
        unique case (state_reg)
            pdw_pkg::PDW_IDLE: begin
                if (i_req) begin
                    rs_next = i_req_setup;
                    bus_next = i_req_setup ?
                        pdw_setup_word(i_speed_choice, i_powerdown_ctl,
                            pdw_ref_fix(i_ref_choice, i_ext_ref_present)) :
                        i_code;
                    sel_n_next = 1'b0;
                    cnt_next = 4'(SEL_CYC);
                    state_next = pdw_pkg::PDW_SEL;
                end
            end
            pdw_pkg::PDW_SEL: begin
                if (cnt_reg <= 4'h1) begin
                    we_n_next = 1'b0;
                    cnt_next = 4'(SU_CYC);
                    state_next = pdw_pkg::PDW_STROBE;
                end else begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end
            pdw_pkg::PDW_STROBE: begin
                if (cnt_reg <= 4'h1) begin
                    we_n_next = 1'b1;              // capture edge
                    cnt_next = 4'(HOLD_CYC);
                    state_next = pdw_pkg::PDW_HOLD;
                end else begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end
            pdw_pkg::PDW_HOLD: begin
                if (cnt_reg <= 4'h1) begin
                    sel_n_next = 1'b1;
                    if (!rs_reg && !i_load_tied) begin
                        ld_n_next = 1'b0;          // one cycle after rise
                        cnt_next = 4'(LD_CYC);
                        state_next = pdw_pkg::PDW_LOAD;
                    end else begin
                        done_next = 1'b1;
                        state_next = pdw_pkg::PDW_IDLE;
                    end
                end else begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end
            pdw_pkg::PDW_LOAD: begin
                if (cnt_reg <= 4'h1) begin
                    ld_n_next = i_load_tied ? 1'b0 : 1'b1;
                    done_next = 1'b1;
                    state_next = pdw_pkg::PDW_IDLE;
                end else begin
                    ld_n_next = 1'b0;
                    cnt_next = cnt_reg - 4'h1;
                end
            end
            default: begin
                state_next = pdw_pkg::PDW_IDLE;
            end
        endcase
        busy_next = (state_next != pdw_pkg::PDW_IDLE);
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            state_reg <= pdw_pkg::PDW_IDLE;
            cnt_reg <= 4'h0;
            bus_reg <= `PDW_DATA_RESET;
            sel_n_reg <= 1'b1;
            we_n_reg <= 1'b1;
            rs_reg <= 1'b0;
            ld_n_reg <= 1'b1;
            done_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            bus_reg <= bus_next;
            sel_n_reg <= sel_n_next;
            we_n_reg <= we_n_next;
            rs_reg <= rs_next;
            ld_n_reg <= ld_n_next;
            done_reg <= done_next;
            busy_reg <= busy_next;
        end
    end

    assign o_parallel_data_bus = bus_reg;
    assign o_select_n = sel_n_reg;
    assign o_write_n = we_n_reg;
    assign o_reg_select = rs_reg;
    assign o_output_load_n = ld_n_reg;
    assign o_done = done_reg;
    assign o_busy = busy_reg;

    // Checks
    sequence strobe_rise_s;
        !o_write_n ##1 o_write_n;
    endsequence

    strobe_select_a: assert property (
        strobe_rise_s |-> !o_select_n && $past(!o_select_n, 2))
        else $error("strobe rose without select held low");
    regsel_stable_a: assert property (
        !o_write_n |-> $stable(o_reg_select) && $stable(o_parallel_data_bus))
        else $error("data or register select moved during strobe");
    data_hold_a: assert property (
        $rose(o_write_n) |=> $stable(o_reg_select) &&
        $stable(o_parallel_data_bus))
        else $error("data or register select moved after strobe rise");
    load_after_we_a: assert property (
        $fell(o_output_load_n) && !i_load_tied |->
        o_write_n && $past(o_write_n))
        else $error("load fell too close to strobe");
    load_width_a: assert property (
        $fell(o_output_load_n) && !i_load_tied |->
        ##LD_CYC (o_output_load_n && o_done))
        else $error("load pulse width wrong");
    tied_load_a: assert property (
        i_load_tied |=> !o_output_load_n)
        else $error("tied load not held low");
    ext_ref_a: assert property (
        !o_write_n && o_reg_select && i_ext_ref_present |->
        o_parallel_data_bus[4] == o_parallel_data_bus[3])
        else $error("internal reference chosen with external applied");
    dont_care_a: assert property (
        !o_write_n && o_reg_select |->
        o_parallel_data_bus[11:5] == 7'h00 && !o_parallel_data_bus[2])
        else $error("don't-care setup bits not zero");
    done_pulse_a: assert property (
        o_done |-> o_select_n ##1 !o_done)
        else $error("done not a single pulse");
endmodule : pdw_host

//--- pdw_pkg.sv
/*
 * Types for the parallel DAC write port controller.
 * Assumes pdw_consts.svh supplies the numeric constants.
 */
package pdw_pkg;
    typedef enum logic [2:0] {
        PDW_IDLE = 3'b000,
        PDW_SEL = 3'b001,
        PDW_STROBE = 3'b010,
        PDW_HOLD = 3'b011,
        PDW_LOAD = 3'b100
    } pdw_state_e;
    typedef enum logic [1:0] {
        PDW_REF_EXT0 = 2'b00,
        PDW_REF_1V024 = 2'b01,
        PDW_REF_2V048 = 2'b10,
        PDW_REF_EXT1 = 2'b11
    } pdw_ref_e;
endpackage : pdw_pkg

//--- tb_pdw_host.sv
/* Self-checking bench for pdw_host against the device model.
   Assumes pdw_host.sv and pdw_dev_model.sv are compiled first. */
`timescale 1ns/1ns
module tb_pdw_host;
    logic clk = 1'b0, rst = 1'b1, req = 1'b0, rq_set = 1'b0;
    logic speed_choice = 1'b0, powerdown_ctl = 1'b0, ext = 1'b0, tied = 1'b0;
    logic [1:0] rf = 2'b00;
    logic [11:0] code = 12'h000, bus, hold, setup, dac;
    logic busy, done, sel_n, wr_n, rsel, ld_n, viol;
    int n_errors = 0, tests_run = 0, cyc = 0, lat;
    initial forever #50 clk = ~clk;
    pdw_host i_dut (.i_clk_sys(clk), .i_reset(rst), .i_req(req),
        .i_req_setup(rq_set), .i_code(code), .i_speed_choice(speed_choice),
        .i_powerdown_ctl(powerdown_ctl), .i_ref_choice(rf), .i_ext_ref_present(ext),
        .i_load_tied(tied), .o_busy(busy), .o_done(done),
        .o_parallel_data_bus(bus), .o_select_n(sel_n), .o_write_n(wr_n),
        .o_reg_select(rsel), .o_output_load_n(ld_n));
    pdw_dev_model i_dev (.i_select_n(sel_n), .i_write_n(wr_n),
        .i_reg_select(rsel), .i_data(bus), .i_load_n(ld_n), .o_hold(hold),
        .o_setup(setup), .o_dac(dac), .o_viol(viol));
    task automatic check(input string what, input logic [11:0] seen,
                         input logic [11:0] exp);
        tests_run++;
        if (seen !== exp) begin
            $display("wrong value %s exp %h seen %h", what, exp, seen);
            n_errors++;
        end
    endtask : check
    // Latency counted in edges after the one that takes the request
    task automatic send(input logic s, input logic [11:0] c);
        @(negedge clk);
        req = 1'b1;
        rq_set = s;
        code = c;
        @(negedge clk);
        req = 1'b0;
        check("busy", {11'h000, busy}, 12'h001);
        lat = 0;
        while (done !== 1'b1 && lat < 20) begin
            @(posedge clk);
            #1 lat++;
        end
        check("busy", {11'h000, busy}, 12'h000);
    endtask : send
    task automatic close_out;
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    always @(posedge clk) begin
        cyc++;
        if (cyc > 2000) begin
            n_errors++;
            close_out();
        end
    end
    initial begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        check("idle pins", {9'h000, sel_n, wr_n, ld_n}, 12'h007);
        check("setup", setup, 12'h000);
        send(1'b0, 12'hFFF);
        check("latency", 12'(lat), 12'h004);
        check("hold", hold, 12'hFFF);
        check("dac", dac, 12'hFFF);
        for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            rf = 2'(i);
            powerdown_ctl = i[0];
            speed_choice = ~i[0];
            send(1'b1, 12'hFE4);
            check("latency", 12'(lat), 12'h003);
            check("setup", setup, {7'h00, rf, 1'b0, powerdown_ctl, speed_choice});
            check("spare bits", bus & 12'hFE4, 12'h000);
            check("hold", hold, 12'hFFF);
        end
        @(negedge clk);
        ext = 1'b1;
        rf = 2'b01;
        send(1'b1, 12'h000);
        check("ext ref", setup, {7'h00, 2'b00, 1'b0, powerdown_ctl, speed_choice});
        @(negedge clk);
        ext = 1'b0;
        tied = 1'b1;
        repeat (2) @(negedge clk);
        check("load low", {11'h000, ld_n}, 12'h000);
        send(1'b0, 12'h000);
        check("latency", 12'(lat), 12'h003);
        check("dac", dac, 12'h000);
        check("load spacing", {11'h000, viol}, 12'h000);
        close_out();
    end
endmodule : tb_pdw_host
